/* fsl_pkg.sv */
`default_nettype none

package fsl_pkg;

    // Clock rate of the system clock
    localparam int CLK_HZ          = 50_000_000;

    // Pattern times in their own units
    localparam int BLINK_FREQ_DHZ  = 25;     // Blink rate, 2.5 Hz in tenths
    localparam int FLASH_MS        = 200;    // One flash on time
    localparam int PAUSE_MS        = 1000;   // Dark pause after a flash group
    localparam int FLICKER_HZ      = 10;     // Port flicker rate

    // Width of every pattern timer; holds the longest count below
    localparam int TIMER_W         = 26;

    // Cycle counts derived from the times above
    localparam logic [TIMER_W-1:0] BLINK_HALF_CYC =
        TIMER_W'((CLK_HZ / 2 / BLINK_FREQ_DHZ) * 10);
    localparam logic [TIMER_W-1:0] FLASH_CYC =
        TIMER_W'((CLK_HZ / 1000) * FLASH_MS);
    localparam logic [TIMER_W-1:0] PAUSE_CYC =
        TIMER_W'((CLK_HZ / 1000) * PAUSE_MS);
    localparam logic [TIMER_W-1:0] FLICKER_HALF_CYC =
        TIMER_W'(CLK_HZ / 2 / FLICKER_HZ);

    // Communication state codes presented by the slave core
    localparam logic [1:0] STATE_INIT    = 2'h0;
    localparam logic [1:0] STATE_PREOP   = 2'h1;
    localparam logic [1:0] STATE_SAFEOP  = 2'h2;
    localparam logic [1:0] STATE_RUNNING = 2'h3;

    // Reset values
    localparam logic               RESET_LIT   = 1'b0;
    localparam logic [TIMER_W-1:0] RESET_TIMER = '0;

    // Sink pins pull low when active; their data level never changes
    localparam logic SINK_LEVEL = 1'b0;

    // Patterns a status indicator can show
    typedef enum logic [2:0] {
        PAT_OFF    = 3'h0,
        PAT_ON     = 3'h1,
        PAT_BLINK  = 3'h2,
        PAT_SINGLE = 3'h3,
        PAT_DOUBLE = 3'h4
    } fsl_pattern_t;

    // Phases of the pattern sequencer
    typedef enum logic [3:0] {
        PH_ON1   = 4'h1,
        PH_GAP   = 4'h2,
        PH_ON2   = 4'h4,
        PH_PAUSE = 4'h8
    } fsl_phase_t;

endpackage

`default_nettype wire

/* fsl_pattern_gen.sv */
`timescale 1ns/1ps
`default_nettype none

module fsl_pattern_gen
    import fsl_pkg::*;
#(
    parameter logic [TIMER_W-1:0] BLINK_HALF = BLINK_HALF_CYC,
    parameter logic [TIMER_W-1:0] FLASH      = FLASH_CYC,
    parameter logic [TIMER_W-1:0] PAUSE      = PAUSE_CYC
) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         reset_n,
    // Requested pattern
    input  wire fsl_pattern_t mode,
    // Indicator lit, registered
    output logic              lit
);

    fsl_phase_t         phase_reg, phase_next;
    logic [TIMER_W-1:0] timer_reg, timer_next;
    fsl_pattern_t       mode_reg;
    logic               lit_reg, lit_next;

    // Length of the first on phase of a pattern
    function automatic logic [TIMER_W-1:0] first_len(input fsl_pattern_t m);
        first_len = (m == PAT_BLINK) ? BLINK_HALF : FLASH;
    endfunction

    // Sequencer: restart on a new pattern, else count down and step
    always_comb begin
        phase_next = phase_reg;
        timer_next = timer_reg;
        if (mode != mode_reg) begin
            phase_next = PH_ON1;
            timer_next = first_len(mode) - TIMER_W'(1);
        end else if (timer_reg != RESET_TIMER) begin
            timer_next = timer_reg - TIMER_W'(1);
        end else begin
            case (phase_reg)
                PH_ON1: begin
                    if (mode == PAT_BLINK) begin
                        phase_next = PH_GAP;
                        timer_next = BLINK_HALF - TIMER_W'(1);
                    end else if (mode == PAT_SINGLE) begin
                        phase_next = PH_PAUSE;
                        timer_next = PAUSE - TIMER_W'(1);
                    end else if (mode == PAT_DOUBLE) begin
                        phase_next = PH_GAP;
                        timer_next = FLASH - TIMER_W'(1);
                    end
                end
                PH_GAP: begin
                    if (mode == PAT_DOUBLE) begin
                        phase_next = PH_ON2;
                        timer_next = FLASH - TIMER_W'(1);
                    end else begin
                        phase_next = PH_ON1;
                        timer_next = first_len(mode) - TIMER_W'(1);
                    end
                end
                PH_ON2: begin
                    phase_next = PH_PAUSE;
                    timer_next = PAUSE - TIMER_W'(1);
                end
                PH_PAUSE: begin
                    phase_next = PH_ON1;
                    timer_next = FLASH - TIMER_W'(1);
                end
                default: begin
                    phase_next = PH_ON1;
                    timer_next = RESET_TIMER;
                end
            endcase
        end
        // Steady modes ignore the phase; the rest are lit in on phases
        case (mode)
            PAT_OFF: lit_next = 1'b0;
            PAT_ON:  lit_next = 1'b1;
            default: lit_next = (phase_next == PH_ON1) ||
                                (phase_next == PH_ON2);
        endcase
    end

    // Sequencer state
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            phase_reg <= PH_ON1;
            timer_reg <= RESET_TIMER;
            mode_reg  <= PAT_OFF;
            lit_reg   <= RESET_LIT;
        end else begin
            phase_reg <= phase_next;
            timer_reg <= timer_next;
            mode_reg  <= mode;
            lit_reg   <= lit_next;
        end
    end

    assign lit = lit_reg;

    // Unchanged pattern at the end of a timed phase
    sequence s_on1_done;
        phase_reg == PH_ON1 && timer_reg == RESET_TIMER && mode == mode_reg;
    endsequence

    sequence s_pause_done;
        phase_reg == PH_PAUSE && timer_reg == RESET_TIMER &&
        mode == mode_reg;
    endsequence

    a_blink_half: assert property (
        @(posedge clock) disable iff (!reset_n)
        s_on1_done ##0 (mode == PAT_BLINK) |=>
        phase_reg == PH_GAP && timer_reg == BLINK_HALF - TIMER_W'(1) && !lit)
        else $error("blink half period wrong");

    a_single_pause: assert property (
        @(posedge clock) disable iff (!reset_n)
        s_on1_done ##0 (mode == PAT_SINGLE) |=>
        phase_reg == PH_PAUSE && timer_reg == PAUSE - TIMER_W'(1) && !lit)
        else $error("single flash pause wrong");

    a_double_gap: assert property (
        @(posedge clock) disable iff (!reset_n)
        s_on1_done ##0 (mode == PAT_DOUBLE) ##1 (mode == mode_reg) |->
        phase_reg == PH_GAP && !lit &&
        timer_reg == FLASH - TIMER_W'(1))
        else $error("double flash gap wrong");

    a_pause_flash: assert property (
        @(posedge clock) disable iff (!reset_n)
        s_pause_done |=>
        phase_reg == PH_ON1 && lit && timer_reg == FLASH - TIMER_W'(1))
        else $error("flash after pause wrong");

    a_restart_first: assert property (
        @(posedge clock) disable iff (!reset_n)
        mode != mode_reg && mode != PAT_OFF |=>
        phase_reg == PH_ON1 && lit)
        else $error("new pattern did not start lit");

endmodule

`default_nettype wire

/* fsl_status_led.sv */
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Run indicator dark in the initialisation state.
// - Run indicator blinks in the state_preop state.
// - Run indicator single-flashes in the state_safeop state.
// - Run indicator steadily lit in the state_running state.
// - Error indicator dark while no error condition is present.
// - Error indicator double-flashes after an application watchdog timeout.
// - Error indicator single-flashes after an error-forced state change.
// - Error indicator blinks on a general configuration error.
// - Blink toggles continuously at about 2.5 Hz.
// - Flash is 0.2 s on; each group ends with 1 s dark.
// - Separate activity outputs for the input and output ports.
// - Port indicator: closed dark, open idle lit, traffic flickering.
// - Port flicker toggles continuously at about 10 Hz.
// - Status indicators lit by an active open-collector sink.
// - Port indicators lit by sourcing, output high when lit.
module fsl_status_led
    import fsl_pkg::*;
#(
    parameter logic [TIMER_W-1:0] BLINK_HALF_CYCLES   = BLINK_HALF_CYC,
    parameter logic [TIMER_W-1:0] FLASH_CYCLES        = FLASH_CYC,
    parameter logic [TIMER_W-1:0] PAUSE_CYCLES        = PAUSE_CYC,
    parameter logic [TIMER_W-1:0] FLICKER_HALF_CYCLES = FLICKER_HALF_CYC
) (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       reset_n,

    // Slave communication state and error conditions
    input  wire logic [1:0] comm_state,
    input  wire logic       watchdog_timeout,
    input  wire logic       state_safe_with_fault,
    input  wire logic       config_error,

    // Per-port link status
    input  wire logic       in_port_link_open,
    input  wire logic       in_port_traffic,
    input  wire logic       out_port_link_open,
    input  wire logic       out_port_traffic,

    // Run indicator sink pin
    output logic            run_indicator_out,
    output logic            run_indicator_oe,

    // Error indicator sink pin
    output logic            error_indicator_out,
    output logic            error_indicator_oe,

    // Port activity source outputs
    output logic            in_port_activity_out,
    output logic            out_port_activity_out
);

    localparam int NPORTS = 2;

    fsl_pattern_t       run_mode;
    fsl_pattern_t       error_mode;
    logic               run_lit;
    logic               error_lit;

    logic [TIMER_W-1:0] flicker_cnt_reg, flicker_cnt_next;
    logic               flicker_phase_reg, flicker_phase_next;

    logic [NPORTS-1:0]  port_open;
    logic [NPORTS-1:0]  port_traffic;
    logic [NPORTS-1:0]  port_lit_reg;
    logic [NPORTS-1:0]  port_lit_next;

    // Port indicator level for one port
    function automatic logic port_level(input logic open,
                                        input logic traffic,
                                        input logic phase);
        if (!open) begin
            port_level = 1'b0;
        end else if (!traffic) begin
            port_level = 1'b1;
        end else begin
            port_level = phase;
        end
    endfunction

    // Run pattern from the communication state
    always_comb begin
        case (comm_state)
            STATE_INIT:    run_mode = PAT_OFF;
            STATE_PREOP:   run_mode = PAT_BLINK;
            STATE_SAFEOP:  run_mode = PAT_SINGLE;
            STATE_RUNNING: run_mode = PAT_ON;
            default:       run_mode = PAT_OFF;
        endcase
    end

    // Error pattern; configuration errors outrank the others since
    // they block any further state change until corrected
    always_comb begin
        if (config_error) begin
            error_mode = PAT_BLINK;
        end else if (state_safe_with_fault) begin
            error_mode = PAT_SINGLE;
        end else if (watchdog_timeout) begin
            error_mode = PAT_DOUBLE;
        end else begin
            error_mode = PAT_OFF;
        end
    end

    // Run indicator sequencer
    fsl_pattern_gen #(
        .BLINK_HALF (BLINK_HALF_CYCLES),
        .FLASH      (FLASH_CYCLES),
        .PAUSE      (PAUSE_CYCLES)
    ) u_run_pattern (
        .clock      (clock),
        .reset_n    (reset_n),
        .mode       (run_mode),
        .lit        (run_lit)
    );

    // Error indicator sequencer
    fsl_pattern_gen #(
        .BLINK_HALF (BLINK_HALF_CYCLES),
        .FLASH      (FLASH_CYCLES),
        .PAUSE      (PAUSE_CYCLES)
    ) u_error_pattern (
        .clock      (clock),
        .reset_n    (reset_n),
        .mode       (error_mode),
        .lit        (error_lit)
    );

    // Sink pins: enable pulls the LED cathode low, release turns it off
    assign run_indicator_out   = SINK_LEVEL;
    assign run_indicator_oe    = run_lit;
    assign error_indicator_out = SINK_LEVEL;
    assign error_indicator_oe  = error_lit;

    // Free-running flicker timebase, shared by both ports; it is not
    // restarted by traffic so that short bursts still show a toggle
    always_comb begin
        if (flicker_cnt_reg == RESET_TIMER) begin
            flicker_cnt_next   = FLICKER_HALF_CYCLES - TIMER_W'(1);
            flicker_phase_next = !flicker_phase_reg;
        end else begin
            flicker_cnt_next   = flicker_cnt_reg - TIMER_W'(1);
            flicker_phase_next = flicker_phase_reg;
        end
    end

    // Flicker timebase registers
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            flicker_cnt_reg   <= RESET_TIMER;
            flicker_phase_reg <= RESET_LIT;
        end else begin
            flicker_cnt_reg   <= flicker_cnt_next;
            flicker_phase_reg <= flicker_phase_next;
        end
    end

    // Port status gathered by index: 0 is the input port
    assign port_open    = {out_port_link_open, in_port_link_open};
    assign port_traffic = {out_port_traffic, in_port_traffic};

    // One registered activity output per port
    genvar p;
    generate
        for (p = 0; p < NPORTS; p++) begin : g_port
            always_comb begin
                port_lit_next[p] = port_level(port_open[p],
                                              port_traffic[p],
                                              flicker_phase_reg);
            end

            always_ff @(posedge clock or negedge reset_n) begin
                if (!reset_n) begin
                    port_lit_reg[p] <= RESET_LIT;
                end else begin
                    port_lit_reg[p] <= port_lit_next[p];
                end
            end
        end
    endgenerate

    // Source outputs drive high when lit
    assign in_port_activity_out  = port_lit_reg[0];
    assign out_port_activity_out = port_lit_reg[1];

    // No error condition present
    sequence s_no_error;
        !config_error && !state_safe_with_fault && !watchdog_timeout;
    endsequence

    // Only a watchdog timeout has just appeared
    sequence s_wd_alone;
        $rose(watchdog_timeout) && !config_error && !state_safe_with_fault;
    endsequence

    a_run_init_dark: assert property (
        @(posedge clock) disable iff (!reset_n)
        comm_state == STATE_INIT |=> !run_indicator_oe)
        else $error("run indicator lit in init");

    a_run_preop_blink: assert property (
        @(posedge clock) disable iff (!reset_n)
        comm_state == STATE_PREOP && $past(comm_state) != STATE_PREOP
        ##1 comm_state == STATE_PREOP |-> run_indicator_oe)
        else $error("preop blink did not start lit");

    a_run_safeop_flash: assert property (
        @(posedge clock) disable iff (!reset_n)
        $changed(comm_state) && comm_state == STATE_SAFEOP
        ##1 comm_state == STATE_SAFEOP |-> run_indicator_oe)
        else $error("safeop flash did not start lit");

    a_run_on_steady: assert property (
        @(posedge clock) disable iff (!reset_n)
        comm_state == STATE_RUNNING |=> run_indicator_oe)
        else $error("run indicator dark while running");

    a_err_dark_idle: assert property (
        @(posedge clock) disable iff (!reset_n)
        s_no_error |=> !error_indicator_oe)
        else $error("error indicator lit with no error");

    a_err_wd_flash: assert property (
        @(posedge clock) disable iff (!reset_n)
        s_wd_alone ##1 watchdog_timeout |-> error_indicator_oe)
        else $error("watchdog double flash did not start");

    a_err_cfg_blink: assert property (
        @(posedge clock) disable iff (!reset_n)
        $rose(config_error) |=> error_indicator_oe)
        else $error("configuration blink did not start");

    a_sink_level: assert property (
        @(posedge clock) disable iff (!reset_n)
        run_indicator_oe || error_indicator_oe |->
        !run_indicator_out && !error_indicator_out)
        else $error("sink pin driven high");

    a_port_closed: assert property (
        @(posedge clock) disable iff (!reset_n)
        !in_port_link_open |=> !in_port_activity_out)
        else $error("closed input port lit");

    a_port_idle: assert property (
        @(posedge clock) disable iff (!reset_n)
        out_port_link_open && !out_port_traffic |=> out_port_activity_out)
        else $error("open idle output port dark");

    a_flicker_follow: assert property (
        @(posedge clock) disable iff (!reset_n)
        in_port_link_open && in_port_traffic |=>
        in_port_activity_out == $past(flicker_phase_reg))
        else $error("input port flicker wrong");

    a_flicker_reload: assert property (
        @(posedge clock) disable iff (!reset_n)
        flicker_cnt_reg == RESET_TIMER |=>
        flicker_cnt_reg == FLICKER_HALF_CYCLES - TIMER_W'(1) &&
        flicker_phase_reg != $past(flicker_phase_reg))
        else $error("flicker timebase reload wrong");

    a_err_fault_flash: assert property (
        @(posedge clock) disable iff (!reset_n)
        $rose(state_safe_with_fault) && !config_error |=> error_indicator_oe)
        else $error("forced change flash did not start");

    a_run_restart_lit: assert property (
        @(posedge clock) disable iff (!reset_n)
        $changed(comm_state) && comm_state != STATE_INIT |=>
        run_indicator_oe)
        else $error("run pattern did not restart lit");

    a_port_out_closed: assert property (
        @(posedge clock) disable iff (!reset_n)
        !out_port_link_open |=> !out_port_activity_out)
        else $error("closed output port lit");

    a_port_in_idle: assert property (
        @(posedge clock) disable iff (!reset_n)
        in_port_link_open && !in_port_traffic |=> in_port_activity_out)
        else $error("open idle input port dark");

    a_flicker_out: assert property (
        @(posedge clock) disable iff (!reset_n)
        out_port_link_open && out_port_traffic |=>
        out_port_activity_out == $past(flicker_phase_reg))
        else $error("output port flicker wrong");

    a_flicker_count: assert property (
        @(posedge clock) disable iff (!reset_n)
        flicker_cnt_reg != RESET_TIMER |=>
        flicker_cnt_reg == $past(flicker_cnt_reg) - TIMER_W'(1) &&
        $stable(flicker_phase_reg))
        else $error("flicker timebase count wrong");

endmodule

`default_nettype wire

/* fsl_led_board.sv */
`timescale 1ns/1ps
`default_nettype none

module fsl_led_board (
    // Status sink pins
    input  wire logic run_indicator_out,
    input  wire logic run_indicator_oe,
    input  wire logic error_indicator_out,
    input  wire logic error_indicator_oe,
    // Port source pins
    input  wire logic in_port_activity_out,
    input  wire logic out_port_activity_out,
    // LEDs as an observer sees them
    output logic      run_lit,
    output logic      error_lit,
    output logic      in_lit,
    output logic      out_lit
);
    logic run_wire;
    logic error_wire;

    // Released sink lines float up to the board pull-up, so a sink that
    // drives data high would leave its LED dark and show up as a fault
    assign run_wire   = run_indicator_oe ? run_indicator_out : 1'b1;
    assign error_wire = error_indicator_oe ? error_indicator_out : 1'b1;
    assign run_lit    = ~run_wire;   // LED glows while pulled low
    assign error_lit  = ~error_wire;

    // Jack LEDs take current only while their pin is driven high
    assign in_lit  = in_port_activity_out;
    assign out_lit = out_port_activity_out;
endmodule

`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    // Short pattern times so every pattern repeats many times per run
    localparam int B = 4;
    localparam int F = 3;
    localparam int P = 8;
    localparam int H = 2;

    logic       clock;
    logic       reset_n;
    logic [1:0] comm_state;
    logic       watchdog_timeout;
    logic       state_safe_with_fault;
    logic       config_error;
    logic       in_port_link_open;
    logic       in_port_traffic;
    logic       out_port_link_open;
    logic       out_port_traffic;
    logic       run_indicator_out;
    logic       run_indicator_oe;
    logic       error_indicator_out;
    logic       error_indicator_oe;
    logic       in_port_activity_out;
    logic       out_port_activity_out;
    logic       run_lit;
    logic       error_lit;
    logic       in_lit;
    logic       out_lit;
    logic [3:0] lit;
    logic [3:0] hist [4];
    int         pat [4];
    int         tcnt [4];
    int         newp [4];
    int         n_mismatch = 0;
    int         checks_done = 0;
    int         seed = 1;

    fsl_status_led #(
        .BLINK_HALF_CYCLES   (fsl_pkg::TIMER_W'(B)),
        .FLASH_CYCLES        (fsl_pkg::TIMER_W'(F)),
        .PAUSE_CYCLES        (fsl_pkg::TIMER_W'(P)),
        .FLICKER_HALF_CYCLES (fsl_pkg::TIMER_W'(H))
    ) i_dut (
        .clock                 (clock),
        .reset_n               (reset_n),
        .comm_state            (comm_state),
        .watchdog_timeout      (watchdog_timeout),
        .state_safe_with_fault (state_safe_with_fault),
        .config_error          (config_error),
        .in_port_link_open     (in_port_link_open),
        .in_port_traffic       (in_port_traffic),
        .out_port_link_open    (out_port_link_open),
        .out_port_traffic      (out_port_traffic),
        .run_indicator_out     (run_indicator_out),
        .run_indicator_oe      (run_indicator_oe),
        .error_indicator_out   (error_indicator_out),
        .error_indicator_oe    (error_indicator_oe),
        .in_port_activity_out  (in_port_activity_out),
        .out_port_activity_out (out_port_activity_out)
    );

    fsl_led_board i_board (
        .run_indicator_out     (run_indicator_out),
        .run_indicator_oe      (run_indicator_oe),
        .error_indicator_out   (error_indicator_out),
        .error_indicator_oe    (error_indicator_oe),
        .in_port_activity_out  (in_port_activity_out),
        .out_port_activity_out (out_port_activity_out),
        .run_lit               (run_lit),
        .error_lit             (error_lit),
        .in_lit                (in_lit),
        .out_lit               (out_lit)
    );

    // 50 MHz system clock
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic check(input logic got, input logic exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %b expected %b",
                     $time, what, got, exp);
        end
    endtask

    // Expected level t cycles into a pattern: 0 off, 1 on, 2 blink,
    // 3 single flash, 4 double flash
    function automatic logic expv(input int p, input int t);
        int m;
        m = t % (3 * F + P);
        case (p)
            1: return 1'b1;
            2: return ((t / B) % 2) == 0;
            3: return (t % (F + P)) < F;
            4: return (m < F) || (m >= 2 * F && m < 3 * F);
            default: return 1'b0;
        endcase
    endfunction

    // Flicker phase runs free, so only its period is checked: the level
    // must differ from the one H cycles earlier
    task automatic chk_ind(input int i, input string what);
        if (pat[i] != 5) begin
            check(lit[i], expv(pat[i], tcnt[i]), what);
        end else if (tcnt[i] > H) begin
            check(lit[i], ~hist[i][H-1], what);
        end
    endtask

    task automatic drive(input logic [8:0] v, input int n);
        @(posedge clock);
        {comm_state, config_error, state_safe_with_fault, watchdog_timeout,
         in_port_link_open, in_port_traffic, out_port_link_open,
         out_port_traffic} <= v;
        repeat (n - 1) @(posedge clock);
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Reference model: compare this edge, then take the inputs the next
    // edge samples; a pattern change restarts its cycle count
    always @(posedge clock) begin
        #1;
        // A reset landing on this edge clears every output at once
        if (reset_n !== 1'b1) begin
            for (int i = 0; i < 4; i++) begin
                pat[i] = -1;
            end
        end
        lit = {out_lit, in_lit, error_lit, run_lit};
        chk_ind(0, "run led");
        chk_ind(1, "error led");
        chk_ind(2, "in port led");
        chk_ind(3, "out port led");
        newp[0] = (comm_state == fsl_pkg::STATE_INIT)  ? 0 :
                  (comm_state == fsl_pkg::STATE_PREOP) ? 2 :
                  (comm_state == fsl_pkg::STATE_SAFEOP) ? 3 : 1;
        newp[1] = config_error ? 2 : state_safe_with_fault ? 3 :
                  watchdog_timeout ? 4 : 0;
        newp[2] = !in_port_link_open ? 0 : in_port_traffic ? 5 : 1;
        newp[3] = !out_port_link_open ? 0 : out_port_traffic ? 5 : 1;
        for (int i = 0; i < 4; i++) begin
            hist[i] = {hist[i][2:0], lit[i]};
            if (reset_n !== 1'b1) begin
                newp[i] = -1;
            end
            tcnt[i] = (newp[i] == pat[i]) ? tcnt[i] + 1 : 0;
            pat[i] = newp[i];
        end
    end

    // Main sequence
    initial begin
        reset_n = 1'b0;
        {comm_state, config_error, state_safe_with_fault, watchdog_timeout,
         in_port_link_open, in_port_traffic, out_port_link_open,
         out_port_traffic} = 9'h000;
        for (int i = 0; i < 4; i++) begin
            pat[i] = -1;
            tcnt[i] = 0;
        end
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        for (int s = 0; s < 4; s++) drive({2'(s), 7'h00}, 40);
        for (int e = 0; e < 8; e++) drive({2'h3, 3'(e), 4'h0}, 40);
        for (int p = 0; p < 16; p++) drive({5'h00, 4'(p)}, 20);
        // Short random segments hit back-to-back pattern restarts
        repeat (200) drive(9'($random(seed)),
                           1 + int'($unsigned($random(seed)) % 12));
        // Second reset in mid-pattern, inputs left at state_preop
        drive(9'h080, 10);
        @(posedge clock);
        reset_n <= 1'b0;
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        drive(9'h080, 30);
        end_of_test;
    end

    // Watchdog: the sequence needs about 2150 cycles
    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        $display("mismatch at %0t: sequence did not finish", $time);
        end_of_test;
    end
endmodule

`default_nettype wire
